// [inc/pll_ctrl_pkg.sv]
`default_nettype none
package pll_ctrl_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_DIV_LO = 8'h10;
   localparam logic [7:0] IDX_PHASE = 8'h24;
   localparam logic [7:0] IDX_LD_CNT = 8'h2c;
   localparam logic [7:0] IDX_LD_CFG = 8'h2d;
   localparam logic [7:0] IDX_MUX = 8'h2e;
   localparam logic [7:0] IDX_BLEED = 8'h30;
   localparam logic [7:0] IDX_MODE = 8'h31;
   localparam logic [7:0] IDX_OSC_MAN = 8'h32;
   localparam logic [7:0] IDX_STATUS = 8'h58;
   localparam logic [7:0] IDX_OSC_CAL = 8'h59;
   // field positions
   localparam int LD_LOL_EN_BIT = 0;
   localparam int LD_WIN_EN_BIT = 1;
   localparam int LD_WIN_LSB = 2;
   localparam int BLEED_EN_BIT = 13;
   localparam int BLEED_POLARITY_BIT = 14;
   localparam int MODE_FRAC_BIT = 0;
   localparam int MODE_MANUAL_BIT = 1;
   localparam int ST_LOCK_BIT = 0;
   localparam int ST_CALBUSY_BIT = 1;
   // reset values
   localparam logic [7:0] RST_DIV_LO = 8'h00;
   localparam logic [15:0] RST_PHASE = 16'h0000;
   localparam logic [4:0] RST_LD_CNT = 5'h0a;
   localparam logic [2:0] RST_WIN = 3'h0;
   localparam logic [3:0] RST_MUX = 4'h0;
   localparam logic [12:0] RST_BLEED_MAG = 13'h0000;
   // lock window: phase error units, base width doubled per code step
   localparam logic [9:0] LDWIN_BASE = 10'h004;
   // lock count table: offset of three on a 1.5x / 2x ladder
   localparam logic [20:0] LD_CNT_OFFSET = 21'h000003;
   // mux output selections
   localparam logic [3:0] MUX_LOW = 4'h0;
   localparam logic [3:0] MUX_HIGH = 4'h1;
   localparam logic [3:0] MUX_LOCK = 4'h2;
   localparam logic [3:0] MUX_CALBUSY = 4'h3;
   // bleed setting: coarse 180 uA steps, fine 490 nA steps
   typedef struct packed {
      logic en;
      logic pol;
      logic [3:0] coarse;
      logic [8:0] fine;
   } bleed_s;
   // oscillator selection: 4 cores of 256 bands, plus bias
   typedef struct packed {
      logic [1:0] core;
      logic [7:0] band;
      logic [3:0] bias;
   } osc_s;
endpackage
`default_nettype wire

// [rtl/pll_lock_detect_bleed_ctrl.sv]
// Overview of operation
// R1: detector runs only with both enables set
// R2: lock result drives pin and status bit
// R3: mux output can carry the lock result
// R4: phase error compared against window width
// R5: lock needs consecutive in-window cycle count
// R6: three-bit window code, software picks per mode
// R7: count select maps 0..31 onto 27..1048579
// R8: in window, below count: low, counting
// R9: high after count exceeded, stays in window
// R10: leaving window drops lock at once
// R11: bleed applied only when enabled
// R12: polarity one sources, zero sinks
// R13: magnitude 4-bit coarse, 9-bit fine
// R14: coarse 180 uA, fine 490 nA per step
// R15: software computes magnitude code
// R16: software derives fractional bleed current
// R17: integer bleed polarity shifts output delay
// R18: phase offset applied in fractional mode
// R19: four cores, 256 bands, bias selection
// R20: calibrated values readable for manual reuse
// R21: divider-low write starts oscillator calibration
// R22: counter clears out of window or disabled
`timescale 1ns/10ps
`default_nettype none
module pll_lock_detect_bleed_ctrl (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clkEn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // phase detector measurement
   input wire logic pfdPhaseValid,
   input wire logic [9:0] pfdPhaseErr,
   // calibration engine
   input wire logic calDone,
   input wire pll_ctrl_pkg::osc_s calResult,
   output logic calStart,
   // analog controls and pins
   output pll_ctrl_pkg::bleed_s bleedCtrl,
   output logic [15:0] phaseOffset,
   output logic [7:0] intDivLow,
   output pll_ctrl_pkg::osc_s oscSel,
   output logic lockIndicatorPin,
   output logic muxOutputPin
);
   import pll_ctrl_pkg::*;
   // assertion clock and reset for the whole block
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   // programmed state
   logic lolEnable; // loss-of-lock enable
   logic winEnable; // lock window enable
   logic [2:0] lockWindowWidth;
   logic [4:0] lockCycleCountSel;
   logic [3:0] muxSel;
   logic [12:0] bleedMag;
   logic bleedEnable;
   logic bleedPolarity;
   logic fracMode;
   logic manualOsc;
   logic [15:0] phaseAdj;
   osc_s oscManual;
   osc_s oscCal; // calibrated result kept for readback
   logic calBusy;
   // lock detector state
   logic [20:0] cycleCount;
   logic locked;
   // bus decode
   logic [7:0] regIdx;
   logic addrOk;
   logic access;
   logic wrStrobe;
   logic detEnable;
   logic inWindow;

   // required count for a select code; even codes 1.5x, odd codes 2x
   function automatic logic [20:0] ldTarget(input logic [4:0] sel);
      logic [20:0] base;
      // five-bit shift sum: the top codes need a shift of 19, which four bits would wrap
      base = 21'h000001 << ({1'b0, sel[4:1]} + 5'h04);
      if (sel[0]) begin
         ldTarget = (base << 1) + LD_CNT_OFFSET; // R7
      end else begin
         ldTarget = base + (base >> 1) + LD_CNT_OFFSET; // R7
      end
   endfunction

   // window limit doubles with each code step
   function automatic logic [9:0] winLimit(input logic [2:0] code);
      winLimit = LDWIN_BASE << code;
   endfunction

   // oscillator word packing shared by both oscillator registers
   function automatic logic [31:0] oscWord(input osc_s o);
      oscWord = {18'h00000, o.bias, o.band, o.core};
   endfunction

   // register read mux
   function automatic logic [31:0] regRead(input logic [7:0] idx);
      case (idx)
         IDX_DIV_LO: regRead = {24'h000000, intDivLow};
         IDX_PHASE: regRead = {16'h0000, phaseAdj};
         IDX_LD_CNT: regRead = {27'h0000000, lockCycleCountSel};
         IDX_LD_CFG: regRead = {27'h0000000, lockWindowWidth, winEnable, lolEnable};
         IDX_MUX: regRead = {28'h0000000, muxSel};
         IDX_BLEED: regRead = {17'h00000, bleedPolarity, bleedEnable, bleedMag};
         IDX_MODE: regRead = {30'h00000000, manualOsc, fracMode};
         IDX_OSC_MAN: regRead = oscWord(oscManual);
         IDX_OSC_CAL: regRead = oscWord(oscCal); // R20
         IDX_STATUS: regRead = {30'h00000000, calBusy, locked}; // R2
         default: regRead = 32'h00000000;
      endcase
   endfunction

   function automatic logic idxMapped(input logic [7:0] idx);
      case (idx)
         IDX_DIV_LO, IDX_PHASE, IDX_LD_CNT, IDX_LD_CFG, IDX_MUX, IDX_BLEED,
         IDX_MODE, IDX_OSC_MAN, IDX_OSC_CAL, IDX_STATUS: idxMapped = 1'b1;
         default: idxMapped = 1'b0;
      endcase
   endfunction

   assign regIdx = paddr[9:2];
   assign addrOk = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) && idxMapped(regIdx);
   assign access = psel && penable;
   // a write lands only on the edge where pready is seen high
   assign wrStrobe = access && pready && pwrite && addrOk && clkEn;
   assign detEnable = lolEnable && winEnable; // R1
   // phase error between reference and feedback edges vs window
   assign inWindow = pfdPhaseValid && (pfdPhaseErr < winLimit(lockWindowWidth)); // R4

   // apb answer: one wait state, so pready and data both come from flops
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         pready <= access && !pready;
         if (access && !pready) begin
            prdata <= (pwrite || !addrOk) ? 32'h00000000 : regRead(regIdx);
            // unmapped or misaligned addresses, and writes to status or the calibrated oscillator register, error out
            pslverr <= !addrOk || (pwrite && (regIdx == IDX_STATUS || regIdx == IDX_OSC_CAL));
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // lock detector configuration
   always_ff @(posedge core_clk) begin
      if (srst) begin
         lolEnable <= 1'b0;
         winEnable <= 1'b0;
         lockWindowWidth <= RST_WIN;
         lockCycleCountSel <= RST_LD_CNT;
         muxSel <= RST_MUX;
      end else if (wrStrobe) begin
         if (regIdx == IDX_LD_CFG) begin
            lolEnable <= pwdata[LD_LOL_EN_BIT];
            winEnable <= pwdata[LD_WIN_EN_BIT];
            lockWindowWidth <= pwdata[LD_WIN_LSB +: 3]; // R6
         end
         if (regIdx == IDX_LD_CNT) begin
            lockCycleCountSel <= pwdata[4:0];
         end
         if (regIdx == IDX_MUX) begin
            muxSel <= pwdata[3:0];
         end
      end
   end

   // bleed, mode and phase settings
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bleedMag <= RST_BLEED_MAG;
         bleedEnable <= 1'b0;
         bleedPolarity <= 1'b0;
         fracMode <= 1'b0;
         manualOsc <= 1'b0;
         phaseAdj <= RST_PHASE;
         oscManual <= '0;
      end else if (wrStrobe) begin
         if (regIdx == IDX_BLEED) begin
            bleedMag <= pwdata[12:0]; // R13
            bleedEnable <= pwdata[BLEED_EN_BIT];
            bleedPolarity <= pwdata[BLEED_POLARITY_BIT];
         end
         if (regIdx == IDX_MODE) begin
            fracMode <= pwdata[MODE_FRAC_BIT];
            manualOsc <= pwdata[MODE_MANUAL_BIT];
         end
         if (regIdx == IDX_PHASE) begin
            phaseAdj <= pwdata[15:0];
         end
         if (regIdx == IDX_OSC_MAN) begin
            // register keeps core in the low bits, the struct keeps it on top
            oscManual <= {pwdata[1:0], pwdata[9:2], pwdata[13:10]}; // R19
         end
      end
   end

   // divider low byte; any write kicks off calibration
   always_ff @(posedge core_clk) begin
      if (srst) begin
         intDivLow <= RST_DIV_LO;
         calStart <= 1'b0;
      end else if (clkEn) begin
         calStart <= wrStrobe && (regIdx == IDX_DIV_LO); // R21
         if (wrStrobe && regIdx == IDX_DIV_LO) begin
            intDivLow <= pwdata[7:0];
         end
      end
   end

   // calibration busy flag and captured result; a new start wins over done
   always_ff @(posedge core_clk) begin
      if (srst) begin
         calBusy <= 1'b0;
         oscCal <= '0;
      end else if (clkEn) begin
         if (wrStrobe && regIdx == IDX_DIV_LO) begin
            calBusy <= 1'b1; // R21
         end else if (calDone) begin
            calBusy <= 1'b0;
         end
         if (calDone) begin
            oscCal <= calResult; // R20
         end
      end
   end

   // in-window cycle counter; saturates one past the target so it never wraps
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cycleCount <= 21'h000000;
      end else if (clkEn) begin
         if (!detEnable || (pfdPhaseValid && !inWindow)) begin
            cycleCount <= 21'h000000; // R22
         end else if (inWindow && cycleCount <= ldTarget(lockCycleCountSel)) begin
            cycleCount <= cycleCount + 21'h000001; // R8
         end
      end
   end

   // lock flag: rises past the count, falls on the first out-of-window cycle
   always_ff @(posedge core_clk) begin
      if (srst) begin
         locked <= 1'b0;
      end else if (clkEn) begin
         if (!detEnable) begin
            locked <= 1'b0; // R1
         end else if (pfdPhaseValid && !inWindow) begin
            locked <= 1'b0; // R10
         end else if (cycleCount > ldTarget(lockCycleCountSel)) begin
            locked <= 1'b1; // R5 R9
         end
      end
   end

   // lock pin follows the flag one edge later, mux pin too when muxSel is MUX_LOCK; both registered
   always_ff @(posedge core_clk) begin
      if (srst) begin
         lockIndicatorPin <= 1'b0;
         muxOutputPin <= 1'b0;
      end else if (clkEn) begin
         lockIndicatorPin <= locked; // R2
         case (muxSel)
            MUX_LOCK: muxOutputPin <= locked; // R3
            MUX_HIGH: muxOutputPin <= 1'b1;
            MUX_CALBUSY: muxOutputPin <= calBusy;
            default: muxOutputPin <= 1'b0;
         endcase
      end
   end

   // analog control words; bleed held off entirely unless enabled
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bleedCtrl <= '0;
         phaseOffset <= 16'h0000;
         oscSel <= '0;
      end else if (clkEn) begin
         bleedCtrl.en <= bleedEnable; // R11
         // polarity is passed even in integer mode where it steers delay
         bleedCtrl.pol <= bleedEnable && bleedPolarity; // R12 R17
         bleedCtrl.coarse <= bleedEnable ? bleedMag[12:9] : 4'h0; // R13 R14
         bleedCtrl.fine <= bleedEnable ? bleedMag[8:0] : 9'h000; // R13 R14
         // offset only reaches the modulator in fractional mode
         phaseOffset <= fracMode ? phaseAdj : 16'h0000; // R18
         oscSel <= manualOsc ? oscManual : oscCal; // R19 R20
      end
   end

   // checks

   sequence s_outWin;
      clkEn && detEnable && pfdPhaseValid && !inWindow;
   endsequence
   sequence s_pastCount;
      clkEn && detEnable && inWindow && cycleCount > ldTarget(lockCycleCountSel);
   endsequence

   property p_lockNeedsEnable;
      !detEnable && clkEn |=> !locked;
   endproperty
   a_lockNeedsEnable: assert property (p_lockNeedsEnable) else $error("lock without enables"); // R1
   property p_pinFollows;
      clkEn |=> lockIndicatorPin == $past(locked);
   endproperty
   a_pinFollows: assert property (p_pinFollows) else $error("pin does not follow lock"); // R2
   property p_muxLock;
      clkEn && muxSel == MUX_LOCK |=> muxOutputPin == $past(locked);
   endproperty
   a_muxLock: assert property (p_muxLock) else $error("mux does not carry lock"); // R3
   property p_dropNow;
      s_outWin |=> !locked ##1 (!lockIndicatorPin || !$past(clkEn));
   endproperty
   a_dropNow: assert property (p_dropNow) else $error("lock not dropped at once"); // R10
   property p_riseAfterCount;
      s_pastCount |=> locked;
   endproperty
   a_riseAfterCount: assert property (p_riseAfterCount) else $error("lock missing past count"); // R9
   property p_noEarlyLock;
      !locked && clkEn && cycleCount <= ldTarget(lockCycleCountSel) |=> !locked;
   endproperty
   a_noEarlyLock: assert property (p_noEarlyLock) else $error("lock before count"); // R5
   property p_counting;
      clkEn && detEnable && inWindow && cycleCount < ldTarget(lockCycleCountSel)
         |=> cycleCount == $past(cycleCount) + 21'h000001;
   endproperty
   a_counting: assert property (p_counting) else $error("counter did not step"); // R8
   property p_countClear;
      s_outWin |=> cycleCount == 21'h000000;
   endproperty
   a_countClear: assert property (p_countClear) else $error("counter not cleared"); // R22
   property p_bleedOff;
      clkEn && !bleedEnable |=> bleedCtrl == '0;
   endproperty
   a_bleedOff: assert property (p_bleedOff) else $error("bleed active while disabled"); // R11
   property p_calKick;
      wrStrobe && regIdx == IDX_DIV_LO |=> calStart && calBusy;
   endproperty
   a_calKick: assert property (p_calKick) else $error("calibration not started"); // R21
   property p_intNoOffset;
      clkEn && !fracMode |=> phaseOffset == 16'h0000;
   endproperty
   a_intNoOffset: assert property (p_intNoOffset) else $error("offset outside fractional"); // R18
endmodule // pll_lock_detect_bleed_ctrl
`default_nettype wire

// [tb/pll_lock_detect_bleed_ctrl_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module pll_lock_detect_bleed_ctrl_tb;
   import pll_ctrl_pkg::*;
   // design stimulus, all given at time zero
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic clkEn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic pfdPhaseValid = 1'b0;
   logic [9:0] pfdPhaseErr = 10'h3ff;
   logic calDone = 1'b0;
   osc_s calResult = 14'h0;
   // design outputs
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic calStart;
   bleed_s bleedCtrl;
   logic [15:0] phaseOffset;
   logic [7:0] intDivLow;
   osc_s oscSel;
   logic lockIndicatorPin;
   logic muxOutputPin;
   // bookkeeping
   int error_cnt = 0;
   int samples_checked = 0;
   int pulses;
   logic [31:0] rd;
   logic er;

   pll_lock_detect_bleed_ctrl uut (.core_clk(core_clk), .srst(srst), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pfdPhaseValid(pfdPhaseValid), .pfdPhaseErr(pfdPhaseErr),
      .calDone(calDone), .calResult(calResult), .calStart(calStart), .bleedCtrl(bleedCtrl),
      .phaseOffset(phaseOffset), .intDivLow(intDivLow), .oscSel(oscSel),
      .lockIndicatorPin(lockIndicatorPin), .muxOutputPin(muxOutputPin));

   // 250 MHz core clock
   initial begin
      forever #2 core_clk = ~core_clk;
   end

   // verdict, reached from the main sequence or the watchdog
   task conclude;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // one apb transfer; no fixed latency assumed, the slave's pready ends it
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // byte address is four times the register index
   task reg_write(input logic [7:0] idx, input logic [31:0] d, input logic expErr);
      apb(1'b1, {2'b00, idx, 2'b00}, d);
      chk(32'(er), 32'(expErr), "write response");
   endtask

   task reg_read(input logic [7:0] idx, input logic [31:0] exp, input logic expErr);
      apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
      chk(32'(er), 32'(expErr), "read response");
      chk(rd, exp, "read data");
   endtask

   // let registered outputs settle, then look just after the edge
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // required in-window cycles per count code: 27, then a 2x / 1.5x ladder plus three
   function automatic int target(input int sel);
      if (sel == 0) return 27;
      if (sel % 2) return (1 << (5 + (sel - 1) / 2)) + 3;
      return 3 * (1 << (4 + (sel - 2) / 2)) + 3;
   endfunction

   // software side: bleed current from time, rate and pump current, then the code
   function automatic int bleed_code(input int tPs, input int fMhz, input int iCpUa);
      int iNa;
      int coarse;
      iNa = tPs * fMhz * iCpUa / 1000;
      coarse = iNa / 180000;
      return 512 * coarse + (512 * (iNa - 180000 * coarse) + 125000) / 250000;
   endfunction

   // partial count, break at the window edge, then a full count and a drop
   task lock_run(input int sel, input int w);
      logic [9:0] inWin;
      logic [9:0] outWin;
      int t;
      inWin = 10'((4 << w) - 1);
      outWin = 10'(4 << w);
      t = target(sel);
      reg_write(IDX_LD_CNT, 32'(sel), 1'b0);
      reg_write(IDX_LD_CFG, 32'(w << 2) | 32'h3, 1'b0);
      @(posedge core_clk);
      pfdPhaseValid <= 1'b1;
      pfdPhaseErr <= inWin;
      repeat (t) @(posedge core_clk);
      pfdPhaseErr <= outWin;
      @(posedge core_clk);
      pfdPhaseErr <= inWin;
      tick(t + 2);
      chk(32'(lockIndicatorPin), 32'h0, "lock too early");
      tick(1);
      chk(32'(lockIndicatorPin), 32'h1, "lock missing");
      chk(32'(muxOutputPin), 32'h1, "mux lock missing");
      reg_read(IDX_STATUS, 32'h1, 1'b0);
      // frozen: an out-of-window sample must not move anything until enabled again
      @(posedge core_clk);
      clkEn <= 1'b0;
      pfdPhaseErr <= 10'h3ff;
      tick(4);
      chk(32'(lockIndicatorPin), 32'h1, "lock moved while frozen");
      chk(32'(muxOutputPin), 32'h1, "mux moved while frozen");
      @(posedge core_clk);
      clkEn <= 1'b1;
      tick(2);
      chk(32'(lockIndicatorPin), 32'h0, "lock not dropped");
      chk(32'(muxOutputPin), 32'h0, "mux not dropped");
      $display("test lock sel %0d width %0d done", sel, w);
   endtask

   // watchdog: whole run is under two thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      $display("FAIL %0t watchdog expired", $time);
      conclude();
   end

   initial begin
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      // reset values and refused accesses
      reg_read(IDX_LD_CNT, 32'h0a, 1'b0);
      reg_read(IDX_BLEED, 32'h0, 1'b0);
      reg_read(IDX_STATUS, 32'h0, 1'b0);
      reg_read(8'h11, 32'h0, 1'b1);
      reg_write(IDX_STATUS, 32'h1, 1'b1);
      apb(1'b0, 12'h0b5, 32'h0);
      chk(32'(er), 32'h1, "misaligned");
      $display("test reset and refusals done");
      // bleed enable, polarity and magnitude fields
      reg_write(IDX_BLEED, 32'h7a5b, 1'b0);
      tick(2);
      chk(32'(bleedCtrl), 32'h7a5b, "bleed source");
      reg_write(IDX_BLEED, 32'h3a5b, 1'b0);
      tick(2);
      chk(32'(bleedCtrl), 32'h5a5b, "bleed sink");
      reg_write(IDX_BLEED, 32'h5a5b, 1'b0);
      tick(2);
      chk(32'(bleedCtrl), 32'h0, "bleed off");
      // 390 ps at 250 MHz with 11.1 mA pump: coarse 6, fine 5
      reg_write(IDX_BLEED, 32'h2000 | 32'(bleed_code(390, 250, 11100)), 1'b0);
      tick(2);
      chk(32'(bleedCtrl), 32'h4c05, "bleed from pump current");
      $display("test bleed done");
      // phase offset only reaches the modulator in fractional mode
      reg_write(IDX_PHASE, 32'hbeef, 1'b0);
      reg_write(IDX_MODE, 32'h0, 1'b0);
      tick(2);
      chk(32'(phaseOffset), 32'h0, "phase in integer");
      reg_write(IDX_MODE, 32'h1, 1'b0);
      tick(2);
      chk(32'(phaseOffset), 32'hbeef, "phase in fractional");
      $display("test phase done");
      // calibration start, busy, result readback, manual override
      reg_write(IDX_MUX, 32'(MUX_CALBUSY), 1'b0);
      reg_write(IDX_DIV_LO, 32'h5a, 1'b0);
      pulses = 0;
      repeat (4) begin
         @(posedge core_clk);
         if (calStart === 1'b1) pulses++;
      end
      chk(32'(pulses), 32'h1, "cal start pulse");
      chk(32'(intDivLow), 32'h5a, "divider low");
      chk(32'(muxOutputPin), 32'h1, "mux busy");
      reg_read(IDX_STATUS, 32'h2, 1'b0);
      @(posedge core_clk);
      calDone <= 1'b1;
      calResult <= {2'h2, 8'ha7, 4'h9};
      @(posedge core_clk);
      calDone <= 1'b0;
      reg_read(IDX_STATUS, 32'h0, 1'b0);
      reg_read(IDX_OSC_CAL, 32'({4'h9, 8'ha7, 2'h2}), 1'b0);
      chk(32'(oscSel), 32'({2'h2, 8'ha7, 4'h9}), "calibrated select");
      reg_write(IDX_OSC_MAN, 32'({4'h5, 8'h3c, 2'h1}), 1'b0);
      reg_write(IDX_MODE, 32'h3, 1'b0);
      tick(2);
      chk(32'(oscSel), 32'({2'h1, 8'h3c, 4'h5}), "manual select");
      $display("test calibration done");
      // static mux levels
      reg_write(IDX_MUX, 32'(MUX_HIGH), 1'b0);
      tick(2);
      chk(32'(muxOutputPin), 32'h1, "mux high");
      reg_write(IDX_MUX, 32'(MUX_LOW), 1'b0);
      tick(2);
      chk(32'(muxOutputPin), 32'h0, "mux low");
      $display("test mux levels done");
      // a single enable leaves the detector idle
      reg_write(IDX_LD_CNT, 32'h0, 1'b0);
      for (int en = 1; en < 3; en++) begin
         reg_write(IDX_LD_CFG, 32'(en), 1'b0);
         @(posedge core_clk);
         pfdPhaseValid <= 1'b1;
         pfdPhaseErr <= 10'h000;
         tick(40);
         chk(32'(lockIndicatorPin), 32'h0, "lock while disabled");
         reg_read(IDX_STATUS, 32'h0, 1'b0);
      end
      $display("test disabled detector done");
      // every window code, first count codes
      reg_write(IDX_MUX, 32'(MUX_LOCK), 1'b0);
      for (int i = 0; i < 8; i++) begin
         lock_run(i % 4, i);
      end
      conclude();
   end
endmodule // pll_lock_detect_bleed_ctrl_tb
`default_nettype wire
